//--- logic/ddpc_pkg.sv
// shared constants, types and helpers of the destination pointer and count block
package ddpc_pkg;
   localparam int MAX_STREAMS = 4;
   localparam int ADDR_W = 12;
   localparam int STREAM_SEL_LSB = 6;
   localparam int OFFSET_W = 6;
   localparam int IRQ_W = 8;
   localparam int EOT_LSB = 0;
   localparam int ERR_LSB = 4;
   localparam logic [5:0] DEST_PTR_LO_OFFSET = 6'h24;
   localparam logic [5:0] UNITS_LEFT_OFFSET = 6'h28;
   localparam logic [11:0] STREAM_AREA_END = 12'h100;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h100;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h104;
   localparam logic [31:0] DEST_PTR_RESET = 32'h0000_0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_HALF = 32'h0000_0002;
   localparam logic [31:0] STEP_WORD = 32'h0000_0004;

   typedef enum logic [1:0] {
      UNIT_BYTE = 2'b00,
      UNIT_HALF = 2'b01,
      UNIT_WORD = 2'b10
   } ddpc_unit_width_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_ACTIVE = 2'b10
   } ddpc_state_type;

   typedef struct packed {
      logic enable;
      logic dest_address_step_enable;
      logic [1:0] source_unit_width;
      logic [15:0] programmed_unit_total;
      logic [31:0] start_address;
   } ddpc_stream_ctrl_type;

   typedef struct packed {
      logic unit_delivered;
      logic bus_error;
   } ddpc_stream_event_type;

   typedef struct packed {
      logic [31:0] dest_pointer;
      logic [15:0] remaining_units_field;
      logic armed;
      logic busy;
      logic done;
      logic failed;
   } ddpc_stream_view_type;

   typedef struct packed {
      ddpc_state_type state;
      logic enable_prev;
      logic [31:0] pointer;
      logic [15:0] count;
      logic done;
      logic failed;
   } ddpc_track_state_type;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [7:0] status;
      logic [7:0] mask;
   } ddpc_bus_state_type;

   // reserved width code falls back to byte steps
   function automatic logic [31:0] ddpc_unit_step(input logic [1:0] width);
      logic [31:0] step;
      step = STEP_BYTE;
      case (width)
         UNIT_HALF: step = STEP_HALF;
         UNIT_WORD: step = STEP_WORD;
         default: step = STEP_BYTE;
      endcase
      return step;
   endfunction
endpackage

//--- logic/ddpc_stream_tracker.sv
// per-stream destination pointer and remaining unit counter
`timescale 1ns/1ps
module ddpc_stream_tracker (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // stream engine side
   input wire ddpc_pkg::ddpc_stream_ctrl_type ctrl,
   input wire ddpc_pkg::ddpc_stream_event_type evt,
   // observed state
   output ddpc_pkg::ddpc_stream_view_type view
);
   import ddpc_pkg::*;

   ddpc_track_state_type cur_reg;
   ddpc_track_state_type cur_next;
   logic [31:0] step;
   logic start;

   assign step = ddpc_unit_step(ctrl.source_unit_width);
   assign start = ctrl.enable && !cur_reg.enable_prev;

   always_comb begin
      cur_next = cur_reg;
      cur_next.enable_prev = ctrl.enable;
      cur_next.done = 1'b0;
      cur_next.failed = 1'b0;
      if (cur_reg.state != ST_IDLE && evt.unit_delivered && ctrl.dest_address_step_enable) begin
         cur_next.pointer = cur_reg.pointer + step;
      end
      case (cur_reg.state)
         ST_IDLE: begin
            // pointer only moves on a fresh start, so idle reads pair up
            if (start) begin
               cur_next.state = ST_ARMED;
               cur_next.pointer = ctrl.start_address;
            end
         end
         ST_ARMED: begin
            if (evt.unit_delivered) begin
               // load and first decrement fold into one edge
               if (ctrl.programmed_unit_total <= 16'h0001) begin
                  cur_next.count = COUNT_RESET;
                  cur_next.done = 1'b1;
                  cur_next.state = ST_IDLE;
               end else begin
                  cur_next.count = ctrl.programmed_unit_total - 16'h0001;
                  cur_next.state = evt.bus_error ? ST_IDLE : ST_ACTIVE;
                  cur_next.failed = evt.bus_error;
               end
            end else if (evt.bus_error) begin
               cur_next.count = ctrl.programmed_unit_total;
               cur_next.failed = 1'b1;
               cur_next.state = ST_IDLE;
            end else if (!ctrl.enable) begin
               cur_next.state = ST_IDLE;
            end
         end
         ST_ACTIVE: begin
            if (evt.unit_delivered) begin
               cur_next.count = cur_reg.count - 16'h0001;
            end
            if (evt.unit_delivered && cur_reg.count == 16'h0001) begin
               cur_next.done = 1'b1;
               cur_next.state = ST_IDLE;
            end else if (evt.bus_error) begin
               cur_next.failed = 1'b1;
               cur_next.state = ST_IDLE;
            end else if (!ctrl.enable) begin
               cur_next.state = ST_IDLE;
            end
         end
         default: begin
            cur_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cur_reg.state <= ST_IDLE;
         cur_reg.enable_prev <= 1'b0;
         cur_reg.pointer <= DEST_PTR_RESET;
         cur_reg.count <= COUNT_RESET;
         cur_reg.done <= 1'b0;
         cur_reg.failed <= 1'b0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign view.dest_pointer = cur_reg.pointer;
   assign view.remaining_units_field = cur_reg.count;
   assign view.armed = (cur_reg.state == ST_ARMED);
   assign view.busy = (cur_reg.state != ST_IDLE);
   assign view.done = cur_reg.done;
   assign view.failed = cur_reg.failed;
endmodule

//--- logic/ddpc_top.sv
// destination pointer and terminal count status block of a four-stream dma controller
// Function
// - low pointer half, bits 15:0, read-only at stream offset 0x024, upper bits reserved
// - 32-bit destination pointer is split into high and low 16-bit halves
// - with stepping enabled, pointer advances after each unit written to destination
// - with stepping disabled, pointer stays constant through the transfer
// - halves not latched together; both stay stable while the stream is idle
// - 16-bit read-only remaining unit count at stream offset 0x028
// - one unit equals the programmed source width: byte, half-word or word
// - programmed total is copied into the count right after the first unit
// - count drops by one for every unit delivered to the destination
// - count reaching zero marks the transfer complete
// - on an error halt the count keeps the units not transferred
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ddpc_top #(
   parameter int NUM_STREAMS = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ddpc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // stream engine side
   input wire ddpc_pkg::ddpc_stream_ctrl_type stream_ctrl [NUM_STREAMS],
   input wire ddpc_pkg::ddpc_stream_event_type stream_event [NUM_STREAMS],
   output ddpc_pkg::ddpc_stream_view_type stream_view [NUM_STREAMS],
   output logic [15:0] dest_pointer_high_half [NUM_STREAMS],
   // interrupt
   output logic irq
);
   import ddpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // parameter check

   if (NUM_STREAMS < 1 || NUM_STREAMS > MAX_STREAMS) begin : g_bad_streams
      $error("NUM_STREAMS must lie between 1 and 4");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-stream trackers

   ddpc_stream_view_type view_pad [MAX_STREAMS];
   logic [IRQ_W-1:0] event_set;

   for (genvar i = 0; i < MAX_STREAMS; i++) begin : g_stream
      if (i < NUM_STREAMS) begin : g_used
         ddpc_stream_tracker u_tracker (
            .core_clk(core_clk),
            .resetn(resetn),
            .ctrl(stream_ctrl[i]),
            .evt(stream_event[i]),
            .view(stream_view[i])
         );
         assign view_pad[i] = stream_view[i];
         assign dest_pointer_high_half[i] = stream_view[i].dest_pointer[31:16];
      end else begin : g_unused
         assign view_pad[i] = '0;
      end
      assign event_set[EOT_LSB+i] = view_pad[i].done;
      assign event_set[ERR_LSB+i] = view_pad[i].failed;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address decode and read mux

   logic [1:0] sel_idx;
   logic [OFFSET_W-1:0] sel_off;
   logic hit;
   logic [31:0] rd_val;
   ddpc_stream_view_type sel_view;
   ddpc_bus_state_type bus_reg;
   ddpc_bus_state_type bus_next;

   assign sel_idx = paddr[STREAM_SEL_LSB+1:STREAM_SEL_LSB];
   assign sel_off = paddr[OFFSET_W-1:0];
   assign sel_view = view_pad[sel_idx];

   always_comb begin
      hit = 1'b0;
      rd_val = 32'h0000_0000;
      if (paddr < STREAM_AREA_END) begin
         if (32'(sel_idx) < 32'(NUM_STREAMS)) begin
            if (sel_off == DEST_PTR_LO_OFFSET) begin
               hit = 1'b1;
               rd_val = {16'h0000, sel_view.dest_pointer[15:0]};
            end else if (sel_off == UNITS_LEFT_OFFSET) begin
               hit = 1'b1;
               rd_val = {16'h0000, sel_view.remaining_units_field};
            end
         end
      end else if (paddr == IRQ_STATUS_ADDR) begin
         hit = 1'b1;
         rd_val = {24'h00_0000, bus_reg.status};
      end else if (paddr == IRQ_MASK_ADDR) begin
         hit = 1'b1;
         rd_val = {24'h00_0000, bus_reg.mask};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus state, interrupt status and mask

   logic wr_commit;
   logic [IRQ_W-1:0] clr_bits;

   // one wait state lets read data come straight from a flip-flop
   assign wr_commit = psel && penable && pwrite && bus_reg.ack;

   always_comb begin
      bus_next = bus_reg;
      bus_next.ack = 1'b0;
      clr_bits = '0;
      if (psel && penable && !bus_reg.ack) begin
         bus_next.ack = 1'b1;
         bus_next.err = !hit;
         bus_next.rdata = pwrite ? 32'h0000_0000 : rd_val;
      end
      // stream registers have no write path at all
      if (wr_commit && paddr == IRQ_MASK_ADDR) begin
         bus_next.mask = pwdata[IRQ_W-1:0];
      end
      if (wr_commit && paddr == IRQ_STATUS_ADDR) begin
         clr_bits = pwdata[IRQ_W-1:0];
      end
      // a new event outranks a clear landing in the same cycle
      bus_next.status = (bus_reg.status & ~clr_bits) | event_set;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bus_reg.ack <= 1'b0;
         bus_reg.err <= 1'b0;
         bus_reg.rdata <= 32'h0000_0000;
         bus_reg.status <= IRQ_RESET;
         bus_reg.mask <= IRQ_RESET;
      end else begin
         bus_reg <= bus_next;
      end
   end

   assign pready = bus_reg.ack;
   assign pslverr = bus_reg.ack && bus_reg.err;
   assign prdata = bus_reg.rdata;
   assign irq = |(bus_reg.status & bus_reg.mask);

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the bus side

   AST_ONE_WAIT: assert property (@(posedge core_clk) disable iff (!resetn)
      psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait");

   AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(irq) |-> $past(|(event_set & bus_reg.mask)) || $past(wr_commit))
      else $error("interrupt rose without an unmasked event");

   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
      pready && !pwrite && !pslverr && paddr < STREAM_AREA_END |-> prdata[31:16] == 16'h0000)
      else $error("reserved bits of a stream register not zero");

   AST_READY_PULSE: assert property (@(posedge core_clk) disable iff (!resetn)
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   AST_ERR_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
      psel && penable && !pready |=> pslverr == !$past(hit))
      else $error("error response does not match the address decode");

   AST_ERR_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
      pslverr |-> prdata == 32'h0000_0000)
      else $error("error response carried nonzero data");

   AST_RDATA_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
      !(psel && penable && !pready) |=> $stable(prdata))
      else $error("read data changed outside an access");

   AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
      wr_commit && paddr == IRQ_MASK_ADDR
      |=> bus_reg.mask == $past(pwdata[IRQ_W-1:0]))
      else $error("mask write did not land");

   AST_MASK_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
      !(wr_commit && paddr == IRQ_MASK_ADDR) |=> $stable(bus_reg.mask))
      else $error("mask changed without a write");

   // status is sticky: only an event sets a bit and only a written one clears it
   AST_STATUS_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
      !(|event_set) && !(wr_commit && paddr == IRQ_STATUS_ADDR)
      |=> $stable(bus_reg.status))
      else $error("status changed without event or clear");

   AST_STATUS_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
      wr_commit && paddr == IRQ_STATUS_ADDR
      |=> (bus_reg.status & $past(pwdata[IRQ_W-1:0]) & ~$past(event_set)) == 8'h00)
      else $error("status bit survived a clear");

   AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
      |event_set
      |=> (bus_reg.status & $past(event_set)) == $past(event_set))
      else $error("event lost from status");

   // no disable here: these watch the reset itself
   AST_RESET_BUS: assert property (@(posedge core_clk)
      !resetn |=> !pready && !irq && prdata == 32'h0000_0000
         && bus_reg.status == IRQ_RESET && bus_reg.mask == IRQ_RESET)
      else $error("bus side not cleared by reset");

   ////////////////////////////////////////////////////////////////////////////////
   // checks on each stream

   for (genvar i = 0; i < NUM_STREAMS; i++) begin : g_check
      AST_PTR_STEP: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && stream_event[i].unit_delivered
         && stream_ctrl[i].dest_address_step_enable
         |=> stream_view[i].dest_pointer == $past(stream_view[i].dest_pointer)
            + ddpc_unit_step($past(stream_ctrl[i].source_unit_width)))
         else $error("pointer did not advance by one unit");

      AST_PTR_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && !stream_ctrl[i].dest_address_step_enable
         |=> $stable(stream_view[i].dest_pointer))
         else $error("pointer moved with stepping disabled");

      AST_IDLE_STABLE: assert property (@(posedge core_clk) disable iff (!resetn)
         !stream_view[i].busy && !$rose(stream_ctrl[i].enable)
         |=> $stable(stream_view[i].dest_pointer)
            && $stable(stream_view[i].remaining_units_field))
         else $error("idle stream registers changed");

      AST_COUNT_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].armed && stream_event[i].unit_delivered
         && stream_ctrl[i].programmed_unit_total > 16'h0001
         |=> stream_view[i].remaining_units_field
            == $past(stream_ctrl[i].programmed_unit_total) - 16'h0001)
         else $error("count not loaded at first unit");

      AST_COUNT_DEC: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && !stream_view[i].armed
         && stream_event[i].unit_delivered
         |=> stream_view[i].remaining_units_field
            == $past(stream_view[i].remaining_units_field) - 16'h0001)
         else $error("count did not drop by one");

      AST_DONE_AT_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && !stream_view[i].armed
         && stream_event[i].unit_delivered
         && stream_view[i].remaining_units_field == 16'h0001
         |=> stream_view[i].done && !stream_view[i].busy
            && stream_view[i].remaining_units_field == 16'h0000 ##1 bus_reg.status[EOT_LSB+i])
         else $error("completion not flagged at zero");

      AST_ERR_KEEP: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && !stream_view[i].armed
         && stream_event[i].bus_error && !stream_event[i].unit_delivered
         |=> stream_view[i].failed && !stream_view[i].busy
            && $stable(stream_view[i].remaining_units_field))
         else $error("error halt lost the remaining count");

      AST_LO_READ: assert property (@(posedge core_clk) disable iff (!resetn)
         pready && !pwrite && paddr[STREAM_SEL_LSB+1:STREAM_SEL_LSB] == 2'(i)
         && paddr[OFFSET_W-1:0] == DEST_PTR_LO_OFFSET && paddr < STREAM_AREA_END
         |-> prdata == {16'h0000, $past(stream_view[i].dest_pointer[15:0])})
         else $error("low pointer half read back wrong");

      AST_HI_HALF: assert property (@(posedge core_clk) disable iff (!resetn)
         $rose(stream_view[i].armed)
         |-> {dest_pointer_high_half[i], stream_view[i].dest_pointer[15:0]}
            == $past(stream_ctrl[i].start_address))
         else $error("pointer halves do not join to the start address");

      AST_COUNT_READ: assert property (@(posedge core_clk) disable iff (!resetn)
         pready && !pwrite && paddr[STREAM_SEL_LSB+1:STREAM_SEL_LSB] == 2'(i)
         && paddr[OFFSET_W-1:0] == UNITS_LEFT_OFFSET && paddr < STREAM_AREA_END
         |-> prdata == {16'h0000, $past(stream_view[i].remaining_units_field)})
         else $error("remaining count read back wrong");

      AST_COUNT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].busy && !stream_view[i].armed && !stream_event[i].unit_delivered
         |=> $stable(stream_view[i].remaining_units_field))
         else $error("count moved without a unit");

      AST_START_ARMS: assert property (@(posedge core_clk) disable iff (!resetn)
         !stream_view[i].busy && $rose(stream_ctrl[i].enable) |=> stream_view[i].armed)
         else $error("enable edge did not arm the stream");

      AST_PULSE_ONE: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].done || stream_view[i].failed
         |=> !stream_view[i].done && !stream_view[i].failed)
         else $error("completion or error flag stood two cycles");

      AST_FAIL_STATUS: assert property (@(posedge core_clk) disable iff (!resetn)
         stream_view[i].failed |=> bus_reg.status[ERR_LSB+i])
         else $error("error halt not recorded in status");

      AST_RESET_STREAM: assert property (@(posedge core_clk)
         !resetn |=> stream_view[i].dest_pointer == DEST_PTR_RESET
            && stream_view[i].remaining_units_field == COUNT_RESET && !stream_view[i].busy)
         else $error("stream not cleared by reset");
   end
endmodule

//--- test/ddpc_dest_model.sv
// destination side model: acknowledges units written and reports bus errors
`timescale 1ns/1ps
module ddpc_dest_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // requests from the bench
   input wire logic [3:0] send,
   input wire logic [3:0] fail,
   input wire logic slow,
   // acknowledgements towards the block, idle flags back to the bench
   output ddpc_pkg::ddpc_stream_event_type stream_event [ddpc_pkg::MAX_STREAMS],
   output logic [3:0] idle
);
   import ddpc_pkg::*;
   int pending [MAX_STREAMS];
   int gap [MAX_STREAMS];
   initial begin
      idle = 4'hf;
      foreach (pending[s]) begin
         pending[s] = 0;
         gap[s] = 0;
         stream_event[s] = '0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // slow mode spaces the acknowledgements like a busy memory would
   always @(posedge core_clk) begin
      for (int s = 0; s < MAX_STREAMS; s++) begin
         logic u;
         u = 1'b0;
         if (!resetn) begin
            pending[s] = 0;
            gap[s] = 0;
         end else begin
            pending[s] += int'(send[s]);
            if (pending[s] > 0 && gap[s] > 0) begin
               gap[s]--;
            end else if (pending[s] > 0) begin
               u = 1'b1;
               pending[s]--;
               gap[s] = slow ? $urandom_range(3, 1) : 0;
            end
         end
         stream_event[s] <= '{unit_delivered: u, bus_error: resetn && fail[s] && !u};
         idle[s] <= (pending[s] == 0);
      end
   end
endmodule

//--- test/ddpc_top_tb.sv
// self-checking bench of the destination pointer and count block
`timescale 1ns/1ps
module ddpc_top_tb;
   import ddpc_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   ddpc_stream_ctrl_type ctrl [MAX_STREAMS];
   ddpc_stream_event_type evt [MAX_STREAMS];
   ddpc_stream_view_type view [MAX_STREAMS];
   logic [15:0] hi [MAX_STREAMS];
   logic [3:0] send = '0;
   logic [3:0] fail = '0;
   logic slow = 1'b0;
   logic [3:0] idle;
   logic [32:0] exp_q [$];
   int fail_count = 0;
   int tests_run = 0;

   ddpc_top #(.NUM_STREAMS(MAX_STREAMS)) ddpc_top_i (.core_clk(core_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stream_ctrl(ctrl),
      .stream_event(evt), .stream_view(view), .dest_pointer_high_half(hi), .irq(irq));
   ddpc_dest_model ddpc_dest_model_i (.core_clk(core_clk), .resetn(resetn), .send(send),
      .fail(fail), .slow(slow), .stream_event(evt), .idle(idle));

   always #10 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("mismatches %0d of %0d checks", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   function automatic logic [11:0] ra(input int s, input logic [5:0] off);
      return 12'(s * 64) + 12'(off);
   endfunction
   task automatic units(input int s, input int n);
      int k;
      repeat (n) begin
         @(posedge core_clk);
         send[s] <= 1'b1;
         @(posedge core_clk);
         send[s] <= 1'b0;
      end
      k = 0;
      @(posedge core_clk);
      while (idle !== 4'hf && k < 100) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 100) fail_count++;
      repeat (3) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // one transfer; an error halt after n units when err is set
   task automatic run(input int s, input logic [1:0] w, input logic step,
      input logic [15:0] total, input int n, input logic err);
      logic [31:0] start;
      logic [31:0] stp;
      logic [31:0] p;
      logic [7:0] b;
      start = $urandom;
      stp = !step ? 0 : (w == UNIT_WORD ? 4 : (w == UNIT_HALF ? 2 : 1));
      p = start + 32'(n) * stp;
      b = err ? 8'(1 << (ERR_LSB + s)) : 8'(1 << (EOT_LSB + s));
      @(posedge core_clk);
      ctrl[s] <= '{1'b1, step, w, total, start};
      repeat (2) @(posedge core_clk);
      units(s, 1);
      rd(ra(s, UNITS_LEFT_OFFSET), {17'h0, total - 16'h0001});
      rd(ra(s, DEST_PTR_LO_OFFSET), {17'h0, 16'(start + stp)});
      units(s, n - 1);
      if (err) begin
         @(posedge core_clk);
         fail[s] <= 1'b1;
         @(posedge core_clk);
         fail[s] <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      // upper bits stay zero: writes probe read-only behaviour only
      apb(1'b1, ra(s, DEST_PTR_LO_OFFSET), 32'h0000_abcd);
      apb(1'b1, ra(s, UNITS_LEFT_OFFSET), 32'h0000_1234);
      rd(ra(s, UNITS_LEFT_OFFSET), {17'h0, total - 16'(n)});
      rd(ra(s, DEST_PTR_LO_OFFSET), {17'h0, p[15:0]});
      rd(ra(s, DEST_PTR_LO_OFFSET), {17'h0, p[15:0]});
      check({17'h0, hi[s]}, {17'h0, p[31:16]});
      check({32'h0, view[s].busy}, 33'h0);
      check({32'h0, irq}, 33'h1);
      rd(IRQ_STATUS_ADDR, {25'h0, b});
      apb(1'b1, IRQ_STATUS_ADDR, {24'h0, b});
      ctrl[s].enable <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({32'h0, irq}, 33'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() > 0) check({pslverr, prdata}, exp_q.pop_front());
         else fail_count++;
      end
   end
   initial begin
      #(20 * 30000);
      fail_count++;
      complete_run();
   end
   initial begin
      foreach (ctrl[s]) ctrl[s] = '0;
      void'($urandom(32'hfd26c616));
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      for (int s = 0; s < MAX_STREAMS; s++) begin
         rd(ra(s, DEST_PTR_LO_OFFSET), 33'h0);
         rd(ra(s, UNITS_LEFT_OFFSET), 33'h0);
      end
      rd(12'h200, 33'h1_0000_0000);
      rd(12'h025, 33'h1_0000_0000);
      apb(1'b1, IRQ_MASK_ADDR, 32'h0000_00ff);
      rd(IRQ_MASK_ADDR, 33'h0_0000_00ff);
      // width code 11 on the last stream must step as byte
      for (int s = 0; s < MAX_STREAMS; s++) begin
         slow <= 1'(s);
         run(s, 2'(s), s != 1, 16'(s + 2), s + 2, 1'b0);
      end
      run(3, UNIT_HALF, 1'b1, 16'h0005, 2, 1'b1);
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      rd(ra(3, UNITS_LEFT_OFFSET), 33'h0);
      rd(IRQ_MASK_ADDR, 33'h0);
      repeat (4) @(posedge core_clk);
      complete_run();
   end
endmodule
